/* File: rtl/cte_gap_counter.sv */
`timescale 1ns/1ns
module cte_gap_counter #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // Control
   input wire logic i_tick,
   input wire logic i_start,
   input wire logic [WIDTH-1:0] i_load,
   // Status
   output logic o_done
);

   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;

   // Load on start, count down one per memory clock edge
   always_comb begin
      cnt_d = cnt_q;
      if (i_start) begin
         cnt_d = i_load;
      end else if (i_tick && (cnt_q != '0)) begin
         cnt_d = cnt_q - WIDTH'(1);
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= '0;
      end else if (i_ce) begin
         cnt_q <= cnt_d;
      end
   end

   assign o_done = (cnt_q == '0);

endmodule : cte_gap_counter

/* File: rtl/cte_pkg.sv */
package cte_pkg;

   // Memory commands presented by the scheduler
   typedef enum logic [2:0] {
      CTE_NOP = 3'h0,
      CTE_MRS = 3'h1,
      CTE_REF = 3'h2,
      CTE_PRE = 3'h3,
      CTE_ACT = 3'h4,
      CTE_WR  = 3'h5,
      CTE_RD  = 3'h6
   } cte_op_e;

   typedef struct packed {
      cte_op_e op;
      logic [2:0] bank;
   } cte_cmd_s;

   localparam int CTE_AW = 8;
   localparam int CTE_GW = 8;

   // Register byte offsets
   localparam logic [7:0] CTE_OFF_BANK_CFG = 8'h00;
   localparam logic [7:0] CTE_OFF_REFRESH = 8'h04;
   localparam logic [7:0] CTE_OFF_TIMING = 8'h08;
   localparam logic [7:0] CTE_OFF_TIMING2 = 8'h0c;
   localparam logic [7:0] CTE_OFF_STATUS = 8'h10;

   // Bank configuration
   localparam int CTE_UNLOCK_BIT = 15;
   localparam logic [31:0] CTE_BANK_CFG_MASK = 32'h0000_8000;
   localparam logic [31:0] CTE_BANK_CFG_RST = 32'h0000_0000;

   // Refresh control
   localparam logic [15:0] CTE_RI_RST = 16'h0884;
   localparam logic [15:0] CTE_RI_MIN = 16'h0100;

   // First timing register fields
   localparam int CTE_RFC_LSB = 25;
   localparam int CTE_RFC_W = 7;
   localparam int CTE_RP_LSB = 22;
   localparam int CTE_RCD_LSB = 19;
   localparam int CTE_WR_LSB = 16;
   localparam int CTE_RAS_LSB = 11;
   localparam int CTE_RC_LSB = 6;
   localparam int CTE_RRD_LSB = 3;
   localparam int CTE_WTR_LSB = 0;
   localparam int CTE_W3 = 3;
   localparam int CTE_W5 = 5;
   localparam int CTE_W2 = 2;
   localparam logic [31:0] CTE_TIM_MASK = 32'hffff_fffb;
   localparam logic [31:0] CTE_TIM_RST = 32'h0000_0000;

   // Second timing register fields
   localparam int CTE_XSNR_LSB = 16;
   localparam int CTE_XSNR_W = 7;
   localparam int CTE_XSRD_LSB = 8;
   localparam int CTE_XSRD_W = 8;
   localparam int CTE_RTP_LSB = 5;
   localparam int CTE_CKE_LSB = 0;
   localparam logic [31:0] CTE_TIM2_MASK = 32'h01ff_ffff;
   localparam logic [31:0] CTE_TIM2_RST = 32'h001d_f145;

   // Gap counter indices
   localparam int CTE_G_RFC = 0;
   localparam int CTE_G_RP = 1;
   localparam int CTE_G_RCD = 2;
   localparam int CTE_G_WR = 3;
   localparam int CTE_G_RAS = 4;
   localparam int CTE_G_RC = 5;
   localparam int CTE_G_RRD = 6;
   localparam int CTE_G_WTR = 7;
   localparam int CTE_G_XSNR = 8;
   localparam int CTE_G_XSRD = 9;
   localparam int CTE_G_RTP = 10;
   localparam int CTE_G_CKE = 11;
   localparam int CTE_NGAP = 12;

endpackage : cte_pkg

/* File: rtl/cte_timing_enforcer.sv */
// Functional notes
// - After refresh or mode-load, wait rfc gap plus one before refresh or activate.
// - After precharge, wait precharge_gap plus one before refresh or activate.
// - After activate, wait activate_to_access_gap plus one before read or write.
// - After last write transfer, hold precharge for write_recovery_gap plus one.
// - Changing write_recovery_gap by a write starts memory initialization.
// - After activate, no precharge for row_active_min plus one cycles.
// - Successive activates spaced by row_cycle_gap plus one cycles.
// - Activates to different banks spaced by bank_activate_gap plus one.
// - After last write, wait write_to_read_gap plus one before a read.
// - Second timing register writes accepted only while timing unlock is set.
// - After self-refresh exit, non-read commands wait exit gap plus one.
// - After self-refresh exit, reads wait read exit gap plus one.
// - After last read, precharge waits read_to_precharge_gap plus one.
// - Clock-enable transitions spaced by clock_enable_hold plus one cycles.
// - Reserved bits 24-23 of second timing register have undefined reset.
// - First timing register writes accepted only while timing unlock is set.
// - Refresh interval writes below 0100h load twice the refresh cycle gap.
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
module cte_timing_enforcer (
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [cte_pkg::CTE_AW-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Memory clock from the link
   input wire logic i_mem_clk,
   // Command request from scheduler
   input wire logic i_cmd_valid,
   input wire cte_pkg::cte_cmd_s i_cmd,
   output logic o_cmd_ready,
   input wire logic i_cke_req,
   // Command stream to memory
   output logic o_cmd_valid,
   output cte_pkg::cte_cmd_s o_cmd,
   output logic o_mem_cke,
   // System outputs
   output logic o_init_start,
   output logic [15:0] o_refresh_interval
);
   import cte_pkg::*;

   // All register state of the block; the gap counters sit in their own instances
   typedef struct packed {
      logic [2:0] sync;
      logic ack;
      logic [31:0] rdat;
      logic [31:0] bank_cfg;
      logic [15:0] refresh;
      logic [31:0] timing;
      logic [31:0] timing2;
      logic cke;
      logic cmd_valid;
      cte_cmd_s cmd;
      logic [2:0] last_bank;
      logic init_start;
   } cte_state_s;

   cte_state_s q;
   cte_state_s d;

   // Decoded strobes and qualifiers
   logic tick;
   logic unlock;
   logic bus_wr;
   logic cke_change;
   logic sr_exit;
   logic allowed;
   logic issue;

   // Gap counter wiring, one lane per tracked spacing
   logic [CTE_NGAP-1:0] gap_done;
   logic [CTE_NGAP-1:0] gap_start;
   logic [CTE_NGAP-1:0][CTE_GW-1:0] gap_load;

   // Candidate register values built from the bus write data
   logic [31:0] wr_val;
   logic [31:0] new_tim;
   logic [15:0] new_ri;

   ////////////////////////////////////////////////////////////////////////////
   // Merge write data under byte enables
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_sel

   ////////////////////////////////////////////////////////////////////////////
   // Memory clock edge, after two synchroniser stages
   // The first stage may go metastable, so only the second stage reads it
   assign tick = q.sync[1] & ~q.sync[2];
   assign unlock = q.bank_cfg[CTE_UNLOCK_BIT];
   assign bus_wr = i_wb_cyc & i_wb_stb & i_wb_we & q.ack;
   assign wr_val = i_wb_dat;

   // Clock enable moves only on a memory clock edge once its hold gap is met
   // A rising clock enable marks the self-refresh exit that the exit gaps time
   assign cke_change = tick & (i_cke_req != q.cke) & gap_done[CTE_G_CKE];
   assign sr_exit = cke_change & i_cke_req;

   // Per-command check against every gap that applies
   always_comb begin
      case (i_cmd.op)
         CTE_REF: begin
            allowed = gap_done[CTE_G_RFC] & gap_done[CTE_G_RP] & gap_done[CTE_G_XSNR];
         end
         CTE_MRS: begin
            allowed = gap_done[CTE_G_XSNR];
         end
         // Same-bank activates are held apart by the row cycle gap alone
         CTE_ACT: begin
            allowed = gap_done[CTE_G_RFC] & gap_done[CTE_G_RP] & gap_done[CTE_G_RC]
                      & (gap_done[CTE_G_RRD] | (i_cmd.bank == q.last_bank))
                      & gap_done[CTE_G_XSNR];
         end
         CTE_PRE: begin
            allowed = gap_done[CTE_G_WR] & gap_done[CTE_G_RAS] & gap_done[CTE_G_RTP]
                      & gap_done[CTE_G_XSNR];
         end
         CTE_WR: begin
            allowed = gap_done[CTE_G_RCD] & gap_done[CTE_G_XSNR];
         end
         CTE_RD: begin
            allowed = gap_done[CTE_G_RCD] & gap_done[CTE_G_WTR] & gap_done[CTE_G_XSRD];
         end
         default: begin
            allowed = 1'b1;
         end
      endcase
   end

   // Issue only on a memory clock edge, with clock enable high and every gap that applies met
   // Never on the tick that moves clock enable, so no command meets a changing edge
   assign issue = i_cmd_valid & tick & q.cke & ~cke_change & allowed;
   assign o_cmd_ready = issue;

   ////////////////////////////////////////////////////////////////////////////
   // Gap starts and reload values
   always_comb begin
      gap_start = '0;
      gap_start[CTE_G_RFC] = issue & ((i_cmd.op == CTE_REF) | (i_cmd.op == CTE_MRS));
      gap_start[CTE_G_RP] = issue & (i_cmd.op == CTE_PRE);
      gap_start[CTE_G_RCD] = issue & (i_cmd.op == CTE_ACT);
      gap_start[CTE_G_WR] = issue & (i_cmd.op == CTE_WR);
      gap_start[CTE_G_RAS] = issue & (i_cmd.op == CTE_ACT);
      gap_start[CTE_G_RC] = issue & (i_cmd.op == CTE_ACT);
      gap_start[CTE_G_RRD] = issue & (i_cmd.op == CTE_ACT);
      gap_start[CTE_G_WTR] = issue & (i_cmd.op == CTE_WR);
      gap_start[CTE_G_XSNR] = sr_exit;
      gap_start[CTE_G_XSRD] = sr_exit;
      gap_start[CTE_G_RTP] = issue & (i_cmd.op == CTE_RD);
      gap_start[CTE_G_CKE] = cke_change;
      // A field of N reloads N, which spaces the next command N+1 ticks away
      gap_load = '0;
      gap_load[CTE_G_RFC] = CTE_GW'(q.timing[CTE_RFC_LSB +: CTE_RFC_W]);
      gap_load[CTE_G_RP] = CTE_GW'(q.timing[CTE_RP_LSB +: CTE_W3]);
      gap_load[CTE_G_RCD] = CTE_GW'(q.timing[CTE_RCD_LSB +: CTE_W3]);
      gap_load[CTE_G_WR] = CTE_GW'(q.timing[CTE_WR_LSB +: CTE_W3]);
      gap_load[CTE_G_RAS] = CTE_GW'(q.timing[CTE_RAS_LSB +: CTE_W5]);
      gap_load[CTE_G_RC] = CTE_GW'(q.timing[CTE_RC_LSB +: CTE_W5]);
      gap_load[CTE_G_RRD] = CTE_GW'(q.timing[CTE_RRD_LSB +: CTE_W3]);
      gap_load[CTE_G_WTR] = CTE_GW'(q.timing[CTE_WTR_LSB +: CTE_W2]);
      gap_load[CTE_G_XSNR] = CTE_GW'(q.timing2[CTE_XSNR_LSB +: CTE_XSNR_W]);
      gap_load[CTE_G_XSRD] = CTE_GW'(q.timing2[CTE_XSRD_LSB +: CTE_XSRD_W]);
      gap_load[CTE_G_RTP] = CTE_GW'(q.timing2[CTE_RTP_LSB +: CTE_W3]);
      gap_load[CTE_G_CKE] = CTE_GW'(q.timing2[CTE_CKE_LSB +: CTE_W5]);
   end

   // One counter per gap, all running together
   // Counters step on the synchronised memory clock edge, not on every system clock
   generate
      for (genvar g = 0; g < CTE_NGAP; g++) begin : g_gap
         cte_gap_counter #(
            .WIDTH(CTE_GW)
         ) u_gap (
            .i_clock(i_clock),
            .i_sys_rst(i_sys_rst),
            .i_ce(i_ce),
            .i_tick(tick),
            .i_start(gap_start[g]),
            .i_load(gap_load[g]),
            .o_done(gap_done[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d = q;
      new_tim = (merge_sel(q.timing, wr_val, i_wb_sel) & CTE_TIM_MASK);
      new_ri = 16'(merge_sel({16'h0000, q.refresh}, wr_val, i_wb_sel));
      d.sync = {q.sync[1:0], i_mem_clk};
      d.cmd_valid = 1'b0;
      d.init_start = 1'b0;

      // Bus answer one cycle after the request, dropped the cycle after
      d.ack = i_wb_cyc & i_wb_stb & ~q.ack;
      if (d.ack) begin
         if (i_wb_adr == CTE_OFF_BANK_CFG) begin
            d.rdat = q.bank_cfg;
         end else if (i_wb_adr == CTE_OFF_REFRESH) begin
            d.rdat = {16'h0000, q.refresh};
         end else if (i_wb_adr == CTE_OFF_TIMING) begin
            d.rdat = q.timing;
         end else if (i_wb_adr == CTE_OFF_TIMING2) begin
            d.rdat = q.timing2;
         end else if (i_wb_adr == CTE_OFF_STATUS) begin
            // Busy lanes read as one while their gap still runs
            d.rdat = {19'h00000, q.cke, ~gap_done};
         end else begin
            d.rdat = 32'h0000_0000;
         end
      end

      // Register writes take effect at the acknowledged edge
      if (bus_wr) begin
         if (i_wb_adr == CTE_OFF_BANK_CFG) begin
            d.bank_cfg = merge_sel(q.bank_cfg, wr_val, i_wb_sel) & CTE_BANK_CFG_MASK;
         end else if (i_wb_adr == CTE_OFF_REFRESH) begin
            // Too short an interval falls back to twice the refresh cycle gap
            if (new_ri < CTE_RI_MIN) begin
               d.refresh = {8'h00, q.timing[CTE_RFC_LSB +: CTE_RFC_W], 1'b0};
            end else begin
               d.refresh = new_ri;
            end
         end else if (i_wb_adr == CTE_OFF_TIMING) begin
            // Locked writes are still acknowledged but leave the register alone
            if (unlock) begin
               d.timing = new_tim;
               // Only a changed write recovery field restarts the memory
               if (new_tim[CTE_WR_LSB +: CTE_W3] != q.timing[CTE_WR_LSB +: CTE_W3]) begin
                  d.init_start = 1'b1;
               end
            end
         end else if (i_wb_adr == CTE_OFF_TIMING2) begin
            if (unlock) begin
               d.timing2 = merge_sel(q.timing2, wr_val, i_wb_sel) & CTE_TIM2_MASK;
            end
         end
      end

      // Command and clock enable to memory
      if (issue) begin
         d.cmd_valid = 1'b1;
         d.cmd = i_cmd;
         if (i_cmd.op == CTE_ACT) begin
            d.last_bank = i_cmd.bank;
         end
      end
      if (cke_change) begin
         d.cke = i_cke_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   // Clock enable low freezes every field, the synchroniser included
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q.sync <= 3'h0;
         q.ack <= 1'b0;
         q.rdat <= 32'h0000_0000;
         q.bank_cfg <= CTE_BANK_CFG_RST;
         q.refresh <= CTE_RI_RST;
         q.timing <= CTE_TIM_RST;
         q.timing2 <= CTE_TIM2_RST;
         q.cke <= 1'b0;
         q.cmd_valid <= 1'b0;
         q.cmd <= '{op: CTE_NOP, bank: 3'h0};
         q.last_bank <= 3'h0;
         q.init_start <= 1'b0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   // Outputs
   assign o_wb_dat = q.rdat;
   assign o_wb_ack = q.ack;
   assign o_cmd_valid = q.cmd_valid;
   assign o_cmd = q.cmd;
   assign o_mem_cke = q.cke;
   assign o_init_start = q.init_start;
   assign o_refresh_interval = q.refresh;

endmodule : cte_timing_enforcer

/* File: tb/cte_ddr2_model.sv */
`timescale 1ns/1ns
module cte_ddr2_model (
   // System clock
   input wire logic i_clock,
   // Command stream from the controller
   input wire logic i_cmd_valid,
   input wire logic i_mem_cke,
   // Memory clock and time stamps in memory cycles
   output logic o_mem_clk,
   output logic [31:0] o_cmd_tick,
   output logic [31:0] o_cke_tick
);
   logic [31:0] ticks = 32'h0;
   logic cke_prev = 1'b0;
   // Free-running memory clock, phase offset from the system clock
   initial begin
      o_mem_clk = 1'b0;
      o_cmd_tick = 32'h0;
      o_cke_tick = 32'h0;
      #3;
      forever #40 o_mem_clk = ~o_mem_clk;
   end
   always @(posedge o_mem_clk) ticks <= ticks + 32'h1;
   // Stamp each command and each clock-enable edge with the memory cycle count
   always @(posedge i_clock) begin
      if (i_cmd_valid === 1'b1) o_cmd_tick <= ticks;
      if (i_mem_cke !== cke_prev) o_cke_tick <= ticks;
      cke_prev <= i_mem_cke;
   end
endmodule : cte_ddr2_model

/* File: tb/cte_timing_enforcer_properties.sv */
`timescale 1ns/1ns
module cte_timing_enforcer_properties
   import cte_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // Register bus
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [cte_pkg::CTE_AW-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic o_wb_ack,
   // Command path
   input wire logic i_cmd_valid,
   input wire cte_pkg::cte_cmd_s i_cmd,
   input wire logic o_cmd_ready,
   input wire logic o_cmd_valid,
   input wire cte_pkg::cte_cmd_s o_cmd,
   input wire logic o_mem_cke,
   input wire logic o_init_start
);
   logic unlock_q;
   logic wr_tim;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////
   // Mirror of the unlock bit as software sets it
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         unlock_q <= 1'b0;
      end else if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[1] && i_wb_adr == CTE_OFF_BANK_CFG) begin
         unlock_q <= i_wb_dat[CTE_UNLOCK_BIT];
      end
   end
   assign wr_tim = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_adr == CTE_OFF_TIMING && unlock_q;
   // Quiet spells after an issue or a clock-enable change
   sequence s_cmd_quiet;
      !o_cmd_valid [*6];
   endsequence
   sequence s_cke_quiet;
      $stable(o_mem_cke) [*6];
   endsequence
   ////////////////////////////////////////
   chk_ack_next: assert property (i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("bus request not acknowledged in the next cycle");
   chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("acknowledge longer than one cycle");
   chk_ready_needs_req: assert property (o_cmd_ready |-> i_cmd_valid && o_mem_cke)
      else $error("command taken without request or with clock enable low");
   chk_issue_taken: assert property (o_cmd_ready |=> o_cmd_valid && o_cmd == $past(i_cmd))
      else $error("taken command not issued next cycle");
   chk_issue_cause: assert property (o_cmd_valid |-> $past(o_cmd_ready))
      else $error("command issued without being taken");
   chk_cmd_spacing: assert property (o_cmd_valid |=> s_cmd_quiet)
      else $error("two commands within one memory clock period");
   chk_cke_hold: assert property ($changed(o_mem_cke) |=> s_cke_quiet)
      else $error("clock enable changed again too soon");
   chk_init_cause: assert property (o_init_start |-> $past(wr_tim) || $past(wr_tim, 2))
      else $error("init start without an accepted timing write");
   chk_init_single: assert property (o_init_start |=> !o_init_start)
      else $error("init start longer than one cycle");
endmodule : cte_timing_enforcer_properties

bind cte_timing_enforcer cte_timing_enforcer_properties chk (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
   .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_cmd_valid(o_cmd_valid),
   .o_cmd(o_cmd), .o_mem_cke(o_mem_cke), .o_init_start(o_init_start));

/* File: tb/cte_timing_enforcer_test.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cte_timing_enforcer_test;
   import cte_pkg::*;
   logic i_clock = 1'b0, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_cmd_valid, i_cke_req, i_mem_clk;
   logic o_wb_ack, o_cmd_ready, o_cmd_valid, o_mem_cke, o_init_start;
   logic [7:0] i_wb_adr;
   logic [3:0] i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat, q, cmd_tick, cke_tick, prev;
   logic [15:0] o_refresh_interval;
   cte_cmd_s i_cmd, o_cmd;
   int err_count = 0, tests_run = 0, cycles = 0, inits = 0;
   // Settings kept consistent: row_active_min 6 >= activate_to_access_gap 3 4-bank part
   localparam logic [31:0] TIM = (32'h5 << CTE_RFC_LSB) | (32'h2 << CTE_RP_LSB) | (32'h3 << CTE_RCD_LSB)
      | (32'h6 << CTE_WR_LSB) | (32'h6 << CTE_RAS_LSB) | (32'h9 << CTE_RC_LSB) | (32'h2 << CTE_RRD_LSB) | 32'h1;
   localparam logic [31:0] TIM2 = (32'h3 << CTE_XSNR_LSB) | (32'h4 << CTE_XSRD_LSB) | (32'h3 << CTE_RTP_LSB) | 32'h1;
   localparam logic [31:0] KEEP = 32'hfe7f_ffff;
   ////////////////////////////////////////
   cte_timing_enforcer dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_mem_clk(i_mem_clk), .i_cmd_valid(i_cmd_valid),
      .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_cke_req(i_cke_req), .o_cmd_valid(o_cmd_valid),
      .o_cmd(o_cmd), .o_mem_cke(o_mem_cke), .o_init_start(o_init_start), .o_refresh_interval(o_refresh_interval));
   cte_ddr2_model mem (.i_clock(i_clock), .i_cmd_valid(o_cmd_valid), .i_mem_cke(o_mem_cke),
      .o_mem_clk(i_mem_clk), .o_cmd_tick(cmd_tick), .o_cke_tick(cke_tick));
   // Clock, init pulse counting and hang guard
   always #5 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (o_init_start === 1'b1) inits <= inits + 1;
      if (cycles == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////
   task automatic report_and_stop();
      $display("mismatches=%0d comparisons=%0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   // Classic single bus cycle, read data left in q
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_dat <= d;
      i_wb_sel <= s;
      @(posedge i_clock);
      while (o_wb_ack !== 1'b1) @(posedge i_clock);
      q = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_clock);
   endtask : wb
   // Request one command, check it and its spacing in memory cycles
   task automatic cmd(input cte_op_e op, input logic [2:0] b, input logic [31:0] gap);
      @(posedge i_clock);
      i_cmd_valid <= 1'b1;
      i_cmd <= '{op, b};
      @(negedge i_clock);
      while (o_cmd_ready !== 1'b1) @(negedge i_clock);
      @(posedge i_clock);
      i_cmd_valid <= 1'b0;
      @(negedge i_clock);
      `CHK(o_cmd, cte_cmd_s'{op, b})
      @(posedge i_clock);
      @(negedge i_clock);
      `CHK(cmd_tick - prev, gap)
      prev = cmd_tick;
   endtask : cmd
   task automatic cke(input logic v);
      @(posedge i_clock);
      i_cke_req <= v;
      while (o_mem_cke !== v) @(posedge i_clock);
      @(posedge i_clock);
      @(negedge i_clock);
   endtask : cke
   ////////////////////////////////////////
   initial begin
      {i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_cmd_valid, i_cke_req} = 6'h20;
      {i_wb_adr, i_wb_sel, i_wb_dat, i_cmd} = '0;
      repeat (16) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      `CHK(o_refresh_interval, CTE_RI_RST)
      wb(1'b0, CTE_OFF_TIMING2, 32'h0, 4'hf);
      `CHK(q & KEEP, CTE_TIM2_RST)
      // Locked: both timing registers refuse writes
      wb(1'b1, CTE_OFF_TIMING2, TIM2, 4'hf);
      wb(1'b0, CTE_OFF_TIMING2, 32'h0, 4'hf);
      `CHK(q & KEEP, CTE_TIM2_RST)
      wb(1'b1, CTE_OFF_TIMING, TIM, 4'hf);
      wb(1'b0, CTE_OFF_TIMING, 32'h0, 4'hf);
      `CHK(q, CTE_TIM_RST)
      // Unlock through lane 1; a lane 0 write leaves it set
      wb(1'b1, CTE_OFF_BANK_CFG, 32'h8000, 4'h2);
      wb(1'b1, CTE_OFF_BANK_CFG, 32'h0, 4'h1);
      wb(1'b0, CTE_OFF_BANK_CFG, 32'h0, 4'hf);
      `CHK(q, CTE_BANK_CFG_MASK)
      `CHK(inits, 0)
      wb(1'b1, CTE_OFF_TIMING, TIM, 4'hf);
      wb(1'b0, CTE_OFF_TIMING, 32'h0, 4'hf);
      `CHK(q, TIM)
      `CHK(inits, 1)
      wb(1'b1, CTE_OFF_TIMING, TIM, 4'hf);
      wb(1'b1, CTE_OFF_TIMING2, TIM2, 4'hf);
      `CHK(inits, 1)
      wb(1'b0, CTE_OFF_TIMING2, 32'h0, 4'hf);
      `CHK(q & KEEP, TIM2)
      wb(1'b1, CTE_OFF_REFRESH, 32'h00ff, 4'hf);
      `CHK(o_refresh_interval, 16'h000a)
      wb(1'b1, CTE_OFF_REFRESH, 32'h0100, 4'hf);
      `CHK(o_refresh_interval, 16'h0100)
      wb(1'b0, 8'h40, 32'h0, 4'hf);
      `CHK(q, 32'h0)
      // Command spacing, a gap binding each step except REF and MRS, which go on the next tick
      cke(1'b1);
      prev = cke_tick;
      cmd(CTE_ACT, 3'h0, 32'h4);
      cmd(CTE_RD, 3'h0, 32'h4);
      cmd(CTE_PRE, 3'h0, 32'h4);
      cmd(CTE_ACT, 3'h0, 32'h3);
      cmd(CTE_ACT, 3'h1, 32'ha);
      cmd(CTE_REF, 3'h0, 32'h1);
      cmd(CTE_ACT, 3'h2, 32'h9);
      cmd(CTE_PRE, 3'h2, 32'h7);
      cmd(CTE_MRS, 3'h0, 32'h1);
      cmd(CTE_ACT, 3'h3, 32'h6);
      cmd(CTE_WR, 3'h3, 32'h4);
      cmd(CTE_RD, 3'h3, 32'h2);
      cmd(CTE_PRE, 3'h3, 32'h5);
      // Self-refresh entry and quickest exit
      cke(1'b0);
      prev = cke_tick;
      cke(1'b1);
      `CHK(cke_tick - prev, 32'h2)
      prev = cke_tick;
      cmd(CTE_RD, 3'h3, 32'h5);
      // Status right after the read: clock enable high, read-to-precharge lane busy
      @(posedge i_clock);
      wb(1'b0, CTE_OFF_STATUS, 32'h0, 4'hf);
      `CHK(q, 32'h0000_1400)
      report_and_stop();
   end
endmodule : cte_timing_enforcer_test
